// *** src/prl_cfg.svh ***
// Overview of operation
// - Bit 6 of the rate control register set limits the whole port as one bucket, clear limits each priority in its own bucket.
// - Bit 5 set counts the rate in frames, clear counts it in bits.
// - Bit 4 set raises flow control when the receive rate is exceeded, clear never raises it for that reason.
// - Field 3-2 picks counted frames: 00 all, 01 broadcast multicast and flooded unicast, 10 broadcast and multicast, 11 broadcast.
// - Bit 1 set adds twelve gap bytes per frame to ingress and egress rate sums.
// - Bit 0 set adds eight preamble bytes per frame to ingress and egress rate sums.
// - Priorities 0, 1 and 2 each hold a seven-bit rate in bits 6-0, reset to zero, that shapes their received traffic.
// - Bit 7 of the rate control register and of every priority limit register is read-only and reads zero.
// - Priority limits take effect only when software writes the priority-3 limit register, any write acting as the trigger.
// - Priority 3 holds its own seven-bit rate, reset to zero, shaping its traffic like the others.
`ifndef PRL_CFG_SVH
`define PRL_CFG_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define PRL_ADR_W          12
`define PRL_IDX_W          10
`define PRL_IDX_CTRL       10'h0b6
`define PRL_IDX_PRIO0      10'h0c7
`define PRL_IDX_PRIO1      10'h0c8
`define PRL_IDX_PRIO2      10'h0c9
`define PRL_IDX_PRIO3      10'h0ca
`define PRL_IDX_STATUS     10'h100
`define PRL_IDX_DROPS      10'h101
`define PRL_IDX_PASSES     10'h102
`define PRL_IDX_APPLIED    10'h103

// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define PRL_BIT_PORT       6
`define PRL_BIT_PKT        5
`define PRL_BIT_FC         4
`define PRL_MODE_HI        3
`define PRL_MODE_LO        2
`define PRL_BIT_IFG        1
`define PRL_BIT_PRE        0
`define PRL_FIELD_MSB      6
`define PRL_CTRL_RST       7'h00
`define PRL_RATE_RST       7'h00
`define PRL_RATE_OFF       7'h00
`define PRL_CNT_RST        16'h0000

// ----------------------------------------------------------------
// frame overhead and bucket sizing
// ----------------------------------------------------------------
`define PRL_IFG_BYTES      12'h00c
`define PRL_PRE_BYTES      12'h008
`define PRL_BIT_QUANTUM    24'h000080
`define PRL_BIT_CAP        24'h010000
`define PRL_PKT_CAP        24'h000040
`define PRL_ONE_FRAME      24'h000001
`define PRL_TOK_RST        24'h000000

// ----------------------------------------------------------------
// refill timing at 10 MHz
// ----------------------------------------------------------------
`define PRL_CLK_NS         100
`define PRL_REFILL_NS      100000
`define PRL_REFILL_CYCLES  (`PRL_REFILL_NS / `PRL_CLK_NS)
`define PRL_REFILL_LAST    10'((`PRL_REFILL_CYCLES) - 1)

`endif

// *** src/prl_pkg.sv ***
package prl_pkg;
  typedef enum logic [1:0] {
    PRL_CLASS_ALL,
    PRL_CLASS_BMF,
    PRL_CLASS_BM,
    PRL_CLASS_B
  } prl_class_type;
  typedef logic [6:0]  prl_rate_type;
  typedef logic [23:0] prl_tok_type;
endpackage : prl_pkg

// *** src/prl_frame_cost.sv ***
`timescale 1ns/1ps
`include "prl_cfg.svh"
module prl_frame_cost (
  input  wire logic                  bcast_i,
  input  wire logic                  mcast_i,
  input  wire logic                  flood_i,
  input  wire logic [10:0]           len_i,
  input  wire prl_pkg::prl_class_type class_i,
  input  wire logic                  pkt_mode_i,
  input  wire logic                  ifg_i,
  input  wire logic                  pre_i,
  output logic                       counted_o,
  output prl_pkg::prl_tok_type       cost_o,
  output logic [4:0]                 overhead_o
);
  logic [11:0] ifg_add;
  logic [11:0] pre_add;
  logic [11:0] bytes;

  // ----------------------------------------------------------------
  // frame class filter
  // ----------------------------------------------------------------
  always_comb begin
    unique case (class_i)
      prl_pkg::PRL_CLASS_ALL: counted_o = 1'b1;
      prl_pkg::PRL_CLASS_BMF: counted_o = bcast_i | mcast_i | flood_i;
      prl_pkg::PRL_CLASS_BM:  counted_o = bcast_i | mcast_i;
      prl_pkg::PRL_CLASS_B:   counted_o = bcast_i;
    endcase
  end

  // ----------------------------------------------------------------
  // cost in bits or frames
  // ----------------------------------------------------------------
  assign ifg_add    = ifg_i ? `PRL_IFG_BYTES : 12'h000;
  assign pre_add    = pre_i ? `PRL_PRE_BYTES : 12'h000;
  assign bytes      = {1'b0, len_i} + ifg_add + pre_add;
  assign overhead_o = 5'(ifg_add + pre_add);
  assign cost_o     = pkt_mode_i ? `PRL_ONE_FRAME
                                 : {9'h000, bytes, 3'b000};
endmodule : prl_frame_cost

// *** src/prl_token_bucket.sv ***
`timescale 1ns/1ps
`include "prl_cfg.svh"
module prl_token_bucket (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 refill_i,
  input  wire prl_pkg::prl_rate_type rate_i,
  input  wire logic                 pkt_mode_i,
  input  wire logic                 fc_en_i,
  input  wire logic                 charge_i,
  input  wire prl_pkg::prl_tok_type cost_i,
  output logic                      ok_o,
  output logic                      over_o
);
  prl_pkg::prl_tok_type tokens_reg;
  prl_pkg::prl_tok_type tokens_next;
  prl_pkg::prl_tok_type credit;
  prl_pkg::prl_tok_type cap;
  prl_pkg::prl_tok_type filled;
  logic [24:0]          sum;
  logic                 unlimited;
  logic                 over_next;

  // a zero rate means the bucket never limits
  assign unlimited = rate_i == `PRL_RATE_OFF;
  assign credit    = pkt_mode_i ? {17'h00000, rate_i}
                                : 24'({17'h00000, rate_i} * `PRL_BIT_QUANTUM);
  assign cap       = pkt_mode_i ? `PRL_PKT_CAP : `PRL_BIT_CAP;
  assign sum       = {1'b0, tokens_reg} + {1'b0, credit};
  // clamp on refill also trims a surplus left by a unit change
  assign filled    = !refill_i ? tokens_reg :
                     (sum > {1'b0, cap}) ? cap : sum[23:0];
  assign ok_o      = unlimited || (tokens_reg >= cost_i);

  always_comb begin
    tokens_next = filled;
    if (charge_i && !unlimited) begin
      if (ok_o) begin
        tokens_next = filled - cost_i;
      end else if (fc_en_i) begin
        tokens_next = `PRL_TOK_RST;
      end
    end
  end

  // set wins over the refill clear
  assign over_next = (charge_i && !ok_o && fc_en_i) ||
                     (over_o && !refill_i && fc_en_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tokens_reg <= `PRL_TOK_RST;
      over_o     <= 1'b0;
    end else begin
      tokens_reg <= tokens_next;
      over_o     <= over_next;
    end
  end
endmodule : prl_token_bucket

// *** src/prl_top.sv ***
`timescale 1ns/1ps
`include "prl_cfg.svh"
module prl_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        frm_valid_i,
  input  wire logic [10:0] frm_len_i,
  input  wire logic [1:0]  frm_prio_i,
  input  wire logic        frm_bcast_i,
  input  wire logic        frm_mcast_i,
  input  wire logic        frm_flood_i,
  output logic             verdict_valid_o,
  output logic             verdict_drop_o,
  output logic             flow_ctrl_o,
  output logic      [4:0]  egress_overhead_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [6:0]            ctrl_reg;
  prl_pkg::prl_rate_type shadow_reg  [4];
  prl_pkg::prl_rate_type applied_reg [4];
  logic [15:0]           drops_reg;
  logic [15:0]           passes_reg;
  logic [9:0]            tick_reg;
  logic [31:0]           rd_next;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [`PRL_IDX_W-1:0] idx     = wb_adr_i[`PRL_ADR_W-1:2];
  wire                  req     = wb_cyc_i & wb_stb_i;
  wire                  take    = req & ~wb_ack_o;
  // writes land on the edge the master sees ack, not a cycle early
  wire                  wr_en   = req & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire                  hit_ctl = idx == `PRL_IDX_CTRL;
  wire                  hit_p0  = idx == `PRL_IDX_PRIO0;
  wire                  hit_p1  = idx == `PRL_IDX_PRIO1;
  wire                  hit_p2  = idx == `PRL_IDX_PRIO2;
  wire                  hit_p3  = idx == `PRL_IDX_PRIO3;
  wire                  hit_st  = idx == `PRL_IDX_STATUS;
  wire                  hit_dr  = idx == `PRL_IDX_DROPS;
  wire                  hit_ps  = idx == `PRL_IDX_PASSES;
  wire                  hit_ap  = idx == `PRL_IDX_APPLIED;
  wire [3:0]            hit_p   = {hit_p3, hit_p2, hit_p1, hit_p0};
  wire                  trigger = wr_en & hit_p3;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire                  port_based = ctrl_reg[`PRL_BIT_PORT];
  wire                  pkt_mode   = ctrl_reg[`PRL_BIT_PKT];
  wire                  fc_en      = ctrl_reg[`PRL_BIT_FC];
  wire                  ifg_en     = ctrl_reg[`PRL_BIT_IFG];
  wire                  pre_en     = ctrl_reg[`PRL_BIT_PRE];
  wire prl_pkg::prl_class_type frm_class =
    prl_pkg::prl_class_type'(ctrl_reg[`PRL_MODE_HI:`PRL_MODE_LO]);

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `PRL_CTRL_RST;
    end else if (wr_en && hit_ctl) begin
      ctrl_reg <= wb_dat_i[`PRL_FIELD_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // per-priority limits, staged then applied on trigger
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_limit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          shadow_reg[g] <= `PRL_RATE_RST;
        end else if (wr_en && hit_p[g]) begin
          shadow_reg[g] <= wb_dat_i[`PRL_FIELD_MSB:0];
        end
      end
      // the priority-3 value written now is applied with the rest
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          applied_reg[g] <= `PRL_RATE_RST;
        end else if (trigger) begin
          applied_reg[g] <= (g == 3) ? wb_dat_i[`PRL_FIELD_MSB:0]
                                     : shadow_reg[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // refill tick
  // ----------------------------------------------------------------
  wire tick_done = tick_reg == `PRL_REFILL_LAST;

  always_ff @(posedge clk_i) begin
    if (rst_i || tick_done) begin
      tick_reg <= 10'h000;
    end else begin
      tick_reg <= tick_reg + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // frame classification and cost
  // ----------------------------------------------------------------
  logic                 counted;
  prl_pkg::prl_tok_type cost;
  logic [4:0]           overhead;

  prl_frame_cost u_cost (
    .bcast_i    (frm_bcast_i),
    .mcast_i    (frm_mcast_i),
    .flood_i    (frm_flood_i),
    .len_i      (frm_len_i),
    .class_i    (frm_class),
    .pkt_mode_i (pkt_mode),
    .ifg_i      (ifg_en),
    .pre_i      (pre_en),
    .counted_o  (counted),
    .cost_o     (cost),
    .overhead_o (overhead)
  );

  // ----------------------------------------------------------------
  // buckets
  // ----------------------------------------------------------------
  // port-based mode runs every frame through bucket 0 at its rate
  wire [1:0] bucket_sel = port_based ? 2'b00 : frm_prio_i;
  wire       charge_any = frm_valid_i & counted;
  logic [3:0] bucket_ok;
  logic [3:0] bucket_over;

  generate
    for (g = 0; g < 4; g++) begin : g_bucket
      wire charge = charge_any & (bucket_sel == 2'(g));
      prl_token_bucket u_bucket (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .refill_i   (tick_done),
        .rate_i     (applied_reg[g]),
        .pkt_mode_i (pkt_mode),
        .fc_en_i    (fc_en),
        .charge_i   (charge),
        .cost_i     (cost),
        .ok_o       (bucket_ok[g]),
        .over_o     (bucket_over[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  // with flow control on, an over-rate frame is kept and the link
  // partner is paused instead
  wire drop_now = charge_any & ~bucket_ok[bucket_sel] & ~fc_en;
  wire fc_now   = fc_en & (|bucket_over);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      verdict_valid_o   <= 1'b0;
      verdict_drop_o    <= 1'b0;
      flow_ctrl_o       <= 1'b0;
      egress_overhead_o <= 5'h00;
    end else begin
      verdict_valid_o   <= frm_valid_i;
      verdict_drop_o    <= drop_now;
      flow_ctrl_o       <= fc_now;
      egress_overhead_o <= overhead;
    end
  end

  // ----------------------------------------------------------------
  // statistics, each cleared by a write to its own register, a frame in the same cycle restarts the count at one
  // ----------------------------------------------------------------
  wire pass_now = frm_valid_i & ~drop_now;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drops_reg <= `PRL_CNT_RST;
    end else if (drop_now) begin
      drops_reg <= (wr_en && hit_dr) ? 16'h0001 : drops_reg + 16'h0001;
    end else if (wr_en && hit_dr) begin
      drops_reg <= `PRL_CNT_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      passes_reg <= `PRL_CNT_RST;
    end else if (pass_now) begin
      passes_reg <= (wr_en && hit_ps) ? 16'h0001 : passes_reg + 16'h0001;
    end else if (wr_en && hit_ps) begin
      passes_reg <= `PRL_CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // read mux, bit 7 of every limit register reads zero
  // ----------------------------------------------------------------
  always_comb begin
    rd_next = 32'h0000_0000;
    if (hit_ctl) begin
      rd_next = {25'h0000000, ctrl_reg};
    end else if (hit_p0) begin
      rd_next = {25'h0000000, shadow_reg[0]};
    end else if (hit_p1) begin
      rd_next = {25'h0000000, shadow_reg[1]};
    end else if (hit_p2) begin
      rd_next = {25'h0000000, shadow_reg[2]};
    end else if (hit_p3) begin
      rd_next = {25'h0000000, shadow_reg[3]};
    end else if (hit_st) begin
      rd_next = {23'h000000, flow_ctrl_o, bucket_over, bucket_ok};
    end else if (hit_dr) begin
      rd_next = {16'h0000, drops_reg};
    end else if (hit_ps) begin
      rd_next = {16'h0000, passes_reg};
    end else if (hit_ap) begin
      rd_next = {1'b0, applied_reg[3], 1'b0, applied_reg[2],
                 1'b0, applied_reg[1], 1'b0, applied_reg[0]};
    end
  end

  // ----------------------------------------------------------------
  // bus answer, one wait cycle, unmapped reads return zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= take;
      wb_dat_o <= take ? rd_next : wb_dat_o;
    end
  end
endmodule : prl_top

// *** testbench/prl_top_asserts.sv ***
`timescale 1ns/1ps
module prl_top_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        frm_valid_i,
  input wire logic [10:0] frm_len_i,
  input wire logic [1:0]  frm_prio_i,
  input wire logic        frm_bcast_i,
  input wire logic        frm_mcast_i,
  input wire logic        frm_flood_i,
  input wire logic        verdict_valid_o,
  input wire logic        verdict_drop_o,
  input wire logic        flow_ctrl_o,
  input wire logic [4:0]  egress_overhead_o
);
  // ----------------------------------------------------------------
  // shadow of the settings, rebuilt from bus writes
  // ----------------------------------------------------------------
  logic [6:0] ctl_reg;
  logic [6:0] stg_reg [4];
  logic [6:0] app_reg [4];
  wire        wr_ok = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire [9:0]  idx   = wb_adr_i[11:2];
  wire [1:0]  pidx  = 2'(idx[1:0] + 2'h1);
  wire        is_p  = (idx >= 10'h0c7) && (idx <= 10'h0ca);
  wire        is_cf = (idx == 10'h0b6) || is_p;
  wire [6:0]  cf_rd = (idx == 10'h0b6) ? ctl_reg : stg_reg[pidx];
  wire [1:0]  bkt   = ctl_reg[6] ? 2'h0 : frm_prio_i;
  wire [1:0]  cls   = ctl_reg[3:2];
  wire [4:0]  oh    = (ctl_reg[1] ? 5'h0c : 5'h00)
                    + (ctl_reg[0] ? 5'h08 : 5'h00);
  wire        cnt   = (cls == 2'h0)
                   || (cls == 2'h1 && (frm_bcast_i|frm_mcast_i|frm_flood_i))
                   || (cls == 2'h2 && (frm_bcast_i | frm_mcast_i))
                   || (cls == 2'h3 && frm_bcast_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= 7'h00;
      stg_reg <= '{default: 7'h00};
      app_reg <= '{default: 7'h00};
    end else if (wr_ok && idx == 10'h0b6) begin
      ctl_reg <= wb_dat_i[6:0];
    end else if (wr_ok && is_p) begin
      stg_reg[pidx] <= wb_dat_i[6:0];
      // staged limits only reach the limiter with the priority-3 write
      if (pidx == 2'h3) begin
        app_reg <= '{stg_reg[0], stg_reg[1], stg_reg[2], wb_dat_i[6:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one cycle pulse after the request");
  chk_read_cfg: assert property (
    wb_ack_o && !wb_we_i && is_cf |-> wb_dat_o == {25'h0, cf_rd})
    else $error("setting read back differs from written value");
  chk_read_applied: assert property (
    wb_ack_o && !wb_we_i && idx == 10'h103 |-> wb_dat_o == {1'b0,
    app_reg[3], 1'b0, app_reg[2], 1'b0, app_reg[1], 1'b0, app_reg[0]})
    else $error("applied limits differ from triggered values");
  chk_verdict_time: assert property (
    !$past(rst_i) |-> verdict_valid_o == $past(frm_valid_i))
    else $error("verdict not one cycle after frame");
  chk_drop_qual: assert property (
    verdict_drop_o |-> verdict_valid_o && !$past(ctl_reg[4]))
    else $error("drop without verdict or with flow control on");
  chk_uncounted_pass: assert property (
    frm_valid_i && !cnt |=> !verdict_drop_o)
    else $error("uncounted frame class was dropped");
  chk_zero_rate: assert property (
    frm_valid_i && app_reg[bkt] == 7'h00 |=> !verdict_drop_o)
    else $error("frame dropped under an unlimited setting");
  chk_fc_quiet: assert property (
    !ctl_reg[4] && !$past(ctl_reg[4]) |-> !flow_ctrl_o)
    else $error("flow control raised while disabled");
  chk_egress_oh: assert property (
    !$past(rst_i) |-> egress_overhead_o == $past(oh))
    else $error("egress overhead does not follow gap and preamble bits");

  cov_drop: cover property (verdict_drop_o);
  cov_flow: cover property ($rose(flow_ctrl_o));
  cov_apply: cover property (wr_ok && idx == 10'h0ca);
endmodule : prl_top_asserts

bind prl_top prl_top_asserts i_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .frm_valid_i, .frm_len_i, .frm_prio_i,
  .frm_bcast_i, .frm_mcast_i, .frm_flood_i, .verdict_valid_o,
  .verdict_drop_o, .flow_ctrl_o, .egress_overhead_o
);

// *** testbench/prl_top_test.sv ***
`timescale 1ns/1ps
module prl_top_test;
  // ----------------------------------------------------------------
  // stimulus and bookkeeping
  // ----------------------------------------------------------------
  localparam logic [11:0] A_CTL = 12'h2d8;
  localparam logic [11:0] A_P0  = 12'h31c;
  localparam logic [11:0] A_P3  = 12'h328;
  localparam logic [11:0] A_APP = 12'h40c;
  localparam int          LIMIT = 20000;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        wb_cyc_i    = 1'b0;
  logic        wb_stb_i    = 1'b0;
  logic        wb_we_i     = 1'b0;
  logic [11:0] wb_adr_i    = 12'h000;
  logic [3:0]  wb_sel_i    = 4'hf;
  logic [31:0] wb_dat_i    = 32'h0;
  logic        frm_valid_i = 1'b0;
  logic [10:0] frm_len_i   = 11'h000;
  logic [1:0]  frm_prio_i  = 2'h0;
  logic        frm_bcast_i = 1'b0;
  logic        frm_mcast_i = 1'b0;
  logic        frm_flood_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        verdict_valid_o;
  logic        verdict_drop_o;
  logic        flow_ctrl_o;
  logic [4:0]  egress_overhead_o;
  int          fail_count  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  prl_top i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .frm_valid_i, .frm_len_i, .frm_prio_i,
    .frm_bcast_i, .frm_mcast_i, .frm_flood_i, .verdict_valid_o,
    .verdict_drop_o, .flow_ctrl_o, .egress_overhead_o
  );

  always #50 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic ck(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : ck

  task automatic bus(input logic we, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    ck("ack", 32'(wb_ack_o), 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    ck($sformatf("reg %h", a), r, e);
  endtask : rd

  task automatic probe(input logic [10:0] len, input logic [1:0] pr,
                       input logic [2:0] c, output logic d);
    frm_valid_i <= 1'b1;
    frm_len_i   <= len;
    frm_prio_i  <= pr;
    {frm_bcast_i, frm_mcast_i, frm_flood_i} <= c;
    @(posedge clk_i);
    frm_valid_i <= 1'b0;
    @(posedge clk_i);
    ck("verdict valid", 32'(verdict_valid_o), 32'h1);
    d = verdict_drop_o;
  endtask : probe

  task automatic send(input logic [10:0] len, input logic [1:0] pr,
                      input logic [2:0] c, input logic e);
    logic d;
    probe(len, pr, c, d);
    ck("verdict drop", 32'(d), 32'(e));
  endtask : send

  task automatic tick();
    repeat (1000) @(posedge clk_i);
  endtask : tick

  // drain, then wait for the first pass: that pass marks a refill edge,
  // so later waits of one period land after exactly one refill
  task automatic sync_refill();
    logic d;
    int   n;
    d = 1'b0;
    n = 0;
    while (d !== 1'b1 && n < 1200) begin
      probe(11'd64, 2'h0, 3'h0, d);
      n++;
    end
    while (d !== 1'b0 && n < 1200) begin
      probe(11'd64, 2'h0, 3'h0, d);
      n++;
    end
    ck("refill seen", 32'(d), 32'h0);
  endtask : sync_refill

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    ck("flow ctrl", 32'(flow_ctrl_o), 32'h0);
    rd(A_CTL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(A_P0 + 12'(4 * i), 32'h0);
    end
    rd(12'h004, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(A_CTL, 32'hff);
    rd(A_CTL, 32'h7f);
    wr(A_P0 + 12'h004, 32'hff);
    rd(A_P0 + 12'h004, 32'h7f);
    rd(A_APP, 32'h0);
    wr(A_P3, 32'hff);
    rd(A_P3, 32'h7f);
    rd(A_APP, 32'h7f007f00);
    wr(A_P0 + 12'h004, 32'h0);
    wr(A_P3, 32'h0);
    for (int v = 0; v < 4; v++) begin
      wr(A_CTL, 32'(v));
      repeat (2) @(posedge clk_i);
      ck("overhead", 32'(egress_overhead_o),
         32'(8 * v[0] + 12 * v[1]));
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_police();
    logic [2:0] c;
    logic       e;
    wr(A_CTL, 32'h20);
    // egress queues sit outside this block, their setup is taken as done
    wr(A_P0, 32'h01);
    send(11'd64, 2'h0, 3'h0, 1'b0);
    wr(A_P3, 32'h80);
    send(11'd64, 2'h0, 3'h0, 1'b1);
    sync_refill();
    for (int m = 0; m < 4; m++) begin
      wr(A_CTL, 32'h20 | 32'(m << 2));
      for (int k = 0; k < 4; k++) begin
        c = (k == 0) ? 3'h0 : 3'(1 << (k - 1));
        e = (m == 0) || (m == 1 && c != 3'h0)
            || (m == 2 && c[2:1] != 2'h0) || (m == 3 && c[2]);
        send(11'd64, 2'h0, c, e);
      end
    end
    wr(A_CTL, 32'h60);
    send(11'd64, 2'h1, 3'h0, 1'b1);
    wr(A_CTL, 32'h20);
    send(11'd64, 2'h1, 3'h0, 1'b0);
    tick();
    send(11'd1500, 2'h0, 3'h0, 1'b0);
    send(11'd64, 2'h0, 3'h0, 1'b1);
    wr(A_CTL, 32'h00);
    tick();
    send(11'd16, 2'h0, 3'h0, 1'b0);
    send(11'd1, 2'h0, 3'h0, 1'b1);
    wr(A_CTL, 32'h02);
    tick();
    send(11'd4, 2'h0, 3'h0, 1'b0);
    send(11'd1, 2'h0, 3'h0, 1'b1);
    wr(A_CTL, 32'h01);
    tick();
    send(11'd8, 2'h0, 3'h0, 1'b0);
    send(11'd1, 2'h0, 3'h0, 1'b1);
    wr(A_CTL, 32'h10);
    send(11'd64, 2'h0, 3'h0, 1'b0);
    repeat (2) @(posedge clk_i);
    ck("flow ctrl", 32'(flow_ctrl_o), 32'h1);
    wr(A_CTL, 32'h00);
    repeat (2) @(posedge clk_i);
    ck("flow ctrl", 32'(flow_ctrl_o), 32'h0);
    // counters cleared, then one drop and one pass before the next refill
    wr(12'h404, 32'h0);
    wr(12'h408, 32'h0);
    wr(A_CTL, 32'h20);
    send(11'd64, 2'h0, 3'h0, 1'b1);
    send(11'd64, 2'h1, 3'h0, 1'b0);
    rd(12'h404, 32'h1);
    rd(12'h408, 32'h1);
    $display("test policing done");
  endtask : t_police

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("[FAIL] run length expected below %0d seen %0d", LIMIT, cycles);
      finish_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_regs();
    t_police();
    finish_test();
  end
endmodule : prl_top_test
